// *** pkg/flash_read_pkg.sv ***
// Shared constants and types of the serial flash read-command engine.
// Assumes one system clock; all link pins arrive asynchronously.
package flash_read_pkg;

  localparam int ADDR_W = 22;
  localparam int SFDP_DEPTH = 2048;
  localparam int SFDP_AW = 11;

  localparam logic [7:0] OP_ID_A = 8'h9e;
  localparam logic [7:0] OP_ID_B = 8'h9f;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_SFDP = 8'h5a;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_RD_VECR = 8'h65;
  localparam logic [7:0] OP_WR_VECR = 8'h61;

  localparam logic [4:0] OPCODE_LAST_BIT = 5'h07;
  localparam logic [4:0] ADDR_LAST_BIT = 5'h17;
  localparam logic [4:0] ADDR_LAST_PAIR = 5'h16;
  localparam logic [3:0] DUMMY_DEFAULT = 4'h8;
  localparam logic [3:0] SFDP_DUMMY = 4'h8;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  localparam logic [4:0] ID_UNIQ_POS = 5'h03;
  localparam logic [4:0] ID_EXT_POS = 5'h04;
  localparam logic [4:0] ID_FACT_POS = 5'h06;
  localparam logic [4:0] ID_LEN = 5'h14;
  localparam logic [7:0] UNIQ_LENGTH = 8'h10;
  localparam logic [7:0] FACT_BLANK = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] VECR_RESET = 8'hff;
  localparam int SFDP_WRITTEN = 4;
  localparam logic [31:0] SFDP_HEADER = 32'h53464450;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_ID, CMD_READ, CMD_FAST, CMD_SFDP,
    CMD_DUAL_OUT, CMD_DUAL_IO, CMD_RD_VECR, CMD_WR_VECR
  } cmd_type;

  typedef enum logic [2:0] {
    PH_OPCODE, PH_ADDR, PH_DUMMY, PH_DATA, PH_WRITE, PH_IGNORE
  } phase_type;

  typedef struct packed {
    logic sclk;
    logic chipSelN;
    logic dataLineZeroIn;
    logic dataLineOneIn;
  } pin_in_type;

  typedef struct packed {
    logic dataLineZeroOut;
    logic dataLineZeroOe;
    logic dataLineOneOut;
    logic dataLineOneOe;
  } pin_out_type;

  typedef struct packed {
    pin_in_type s1;
    pin_in_type s2;
    pin_in_type s3;
  } sync_state_type;

  typedef struct packed {
    phase_type phase;
    cmd_type cmd;
    logic [23:0] shiftIn;
    logic [4:0] bitCnt;
    logic [3:0] dummyCnt;
    logic [7:0] outByte;
    logic [3:0] outBits;
    logic [ADDR_W-1:0] addr;
    logic [4:0] idIdx;
    logic [7:0] vecr;
    logic arrayRdEn;
    pin_out_type pins;
  } ctrl_type;

  localparam pin_in_type PIN_IDLE = '{sclk: 1'b0, chipSelN: 1'b1,
    dataLineZeroIn: 1'b0, dataLineOneIn: 1'b0};

  localparam ctrl_type CTRL_RESET = '{phase: PH_OPCODE, cmd: CMD_NONE,
    shiftIn: 24'h0, bitCnt: 5'h00, dummyCnt: 4'h0, outByte: 8'h00,
    outBits: 4'h0, addr: '0, idIdx: 5'h00, vecr: VECR_RESET,
    arrayRdEn: 1'b0, pins: 4'h0};

endpackage

// *** src/spi_pin_sync.sv ***
// Two-stage synchroniser for the link pins plus one history stage.
// Assumes pins are asynchronous to clk_sys; edges come from stages 2/3.
`timescale 1ns/1ps
`default_nettype none
module spi_pin_sync import flash_read_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  input wire pin_in_type pinsRaw,
  output var pin_in_type pinsSync,
  output var pin_in_type pinsPrev
);
  sync_state_type st_ff;
  sync_state_type nxt_st;

  // Stage one feeds stage two only, to keep metastability contained
  always_comb begin
    nxt_st.s1 = pinsRaw;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff <= '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pinsSync = st_ff.s2;
  assign pinsPrev = st_ff.s3;
endmodule
`default_nettype wire

// *** src/discovery_rom.sv ***
// Read-only discovery-parameter area with a registered read port.
// Assumes the address is held stable for at least one clock before use.
`timescale 1ns/1ps
`default_nettype none
module discovery_rom import flash_read_pkg::*; #(
  parameter int DEPTH = SFDP_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [SFDP_AW-1:0] addr,
  output var logic [7:0] rdData
);
  logic [7:0] rdData_ff;
  logic [7:0] nxt_rdData;

  // No write port exists, so nothing can alter the area
  always_comb begin
    nxt_rdData = ERASED_BYTE; // RULE17
    if (int'(addr) < SFDP_WRITTEN && int'(addr) < DEPTH) begin
      nxt_rdData = SFDP_HEADER[8*(SFDP_WRITTEN-1-int'(addr)) +: 8];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdData_ff <= ERASED_BYTE;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  assign rdData = rdData_ff;
endmodule
`default_nettype wire

// *** src/flash_read_engine.sv ***
// Read-command decoder and serial data-out sequencer of a serial flash.
// Assumes link clock period of at least eight clk_sys cycles and an array
// that returns arrayData one clock after arrayAddr changes.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: 65h reads enhanced config, no address, endless
// RULE2: 61h writes enhanced config with one byte
// RULE3: ID: maker byte, two device bytes, 17 unique
// RULE4: Unique block starts 10h, two extended, fourteen factory
// RULE5: Unrequested factory data bytes read 00h
// RULE6: Ignore identification while erase or program
// RULE7: ID bytes out single line, falling edges
// RULE8: Chip select high ends identification, standby
// RULE9: Plain read: opcode, 3 address bytes, no dummy
// RULE10: Single reads advance address, wrap to zero
// RULE11: Top two address bits ignored
// RULE12: Reject array reads while modify cycle runs
// RULE13: Fast read: address then dummy byte
// RULE14: Fast read dummy count set by user
// RULE15: 5Ah: address, eight dummies, discovery bytes out
// RULE16: 2048-byte discovery area, never writable
// RULE17: Unwritten discovery bytes read FFh
// RULE18: Chip select high ends discovery read
// RULE19: Dual output: two bits per falling edge
// RULE20: Dual output advances address, wraps to zero
// RULE21: Dual I/O: address two bits per edge
// RULE22: 0Bh is single fast read, 8 dummies
// RULE23: 3Bh is dual output read, 8 dummies
// RULE24: BBh is dual I/O read, 8 dummies
// RULE25: Everything travels most significant bit first
module flash_read_engine import flash_read_pkg::*; #(
  parameter logic [7:0] MFR_CODE = 8'h5c,   // Arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h3e,   // Arbitrary value
  parameter logic [7:0] MEM_CAPACITY = 8'h7d, // Arbitrary value
  parameter logic [15:0] EXT_ID = 16'h0000  // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire pin_in_type pinsIn,
  input wire logic modifyBusy,
  input wire logic [3:0] fastDummyCycles,
  input wire logic [7:0] arrayData,
  output var pin_out_type pinsOut,
  output var logic [ADDR_W-1:0] arrayAddr,
  output var logic arrayRdEn,
  output var logic [7:0] enhConfig
);
  ctrl_type st_ff;
  ctrl_type nxt_st;
  pin_in_type pinSync;
  pin_in_type pinPrev;
  logic [7:0] sfdpData;
  logic selected;
  logic sclkRise;
  logic sclkFall;
  logic din;
  logic [7:0] opNow;
  logic isDual;
  logic dualIoAddr;
  logic [3:0] dummyNeed;
  logic [23:0] addrShift;
  logic addrDone;
  logic loadByte;
  logic [7:0] srcByte;

  spi_pin_sync u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pinsRaw(pinsIn),
    .pinsSync(pinSync),
    .pinsPrev(pinPrev)
  );

  discovery_rom #(.DEPTH(SFDP_DEPTH)) u_rom ( // RULE16
    .clk_sys(clk_sys),
    .reset(reset),
    .addr(st_ff.addr[SFDP_AW-1:0]),
    .rdData(sfdpData)
  );

  function automatic logic arrayCmd(input cmd_type c);
    return c inside {CMD_READ, CMD_FAST, CMD_DUAL_OUT, CMD_DUAL_IO};
  endfunction

  function automatic logic [7:0] idByte(input logic [4:0] idx);
    logic [7:0] b;
    b = FACT_BLANK;
    case (idx)
      5'h00: b = MFR_CODE; // RULE3
      5'h01: b = MEM_TYPE;
      5'h02: b = MEM_CAPACITY;
      ID_UNIQ_POS: b = UNIQ_LENGTH; // RULE4
      ID_EXT_POS: b = EXT_ID[15:8];
      5'h05: b = EXT_ID[7:0];
      default: b = FACT_BLANK; // RULE5
    endcase
    return b;
  endfunction

  assign selected = !pinSync.chipSelN;
  assign sclkRise = pinSync.sclk && !pinPrev.sclk;
  assign sclkFall = !pinSync.sclk && pinPrev.sclk;
  assign din = pinSync.dataLineZeroIn;
  assign opNow = {st_ff.shiftIn[6:0], din}; // RULE25
  assign isDual = st_ff.cmd inside {CMD_DUAL_OUT, CMD_DUAL_IO};
  assign dualIoAddr = st_ff.cmd == CMD_DUAL_IO;
  // Zero on the dummy input means the default count
  assign dummyNeed = (st_ff.cmd == CMD_SFDP) ? SFDP_DUMMY : // RULE15
    ((fastDummyCycles == 4'h0) ? DUMMY_DEFAULT : fastDummyCycles); // RULE14
  assign addrShift = dualIoAddr ? // RULE21
    {st_ff.shiftIn[21:0], pinSync.dataLineOneIn, din} :
    {st_ff.shiftIn[22:0], din};
  assign addrDone = dualIoAddr ? (st_ff.bitCnt == ADDR_LAST_PAIR) :
    (st_ff.bitCnt == ADDR_LAST_BIT);
  assign loadByte = sclkFall && selected && st_ff.phase == PH_DATA &&
    st_ff.outBits == 4'h0;

  always_comb begin
    srcByte = FACT_BLANK;
    case (st_ff.cmd)
      CMD_ID: srcByte = idByte(st_ff.idIdx);
      CMD_SFDP: srcByte = sfdpData;
      CMD_RD_VECR: srcByte = st_ff.vecr; // RULE1
      CMD_READ, CMD_FAST, CMD_DUAL_OUT, CMD_DUAL_IO: srcByte = arrayData;
      default: srcByte = FACT_BLANK;
    endcase
  end

  always_comb begin
    cmd_type c;
    logic [7:0] b;
    c = CMD_NONE;
    b = 8'h00;
    nxt_st = st_ff;
    if (!selected) begin
      // Deselect ends any command and releases the data lines
      nxt_st.phase = PH_OPCODE; // RULE8 RULE18
      nxt_st.cmd = CMD_NONE;
      nxt_st.bitCnt = 5'h00;
      nxt_st.outBits = 4'h0;
      nxt_st.pins = 4'h0;
    end else if (sclkRise) begin
      case (st_ff.phase)
        PH_OPCODE: begin
          nxt_st.shiftIn = {st_ff.shiftIn[22:0], din};
          nxt_st.bitCnt = st_ff.bitCnt + 5'h01;
          if (st_ff.bitCnt == OPCODE_LAST_BIT) begin
            case (opNow)
              OP_ID_A, OP_ID_B: c = CMD_ID;
              OP_READ: c = CMD_READ; // RULE9
              OP_FAST: c = CMD_FAST; // RULE22
              OP_SFDP: c = CMD_SFDP; // RULE15
              OP_DUAL_OUT: c = CMD_DUAL_OUT; // RULE23
              OP_DUAL_IO: c = CMD_DUAL_IO; // RULE24
              OP_RD_VECR: c = CMD_RD_VECR; // RULE1
              OP_WR_VECR: c = CMD_WR_VECR; // RULE2
              default: c = CMD_NONE;
            endcase
            nxt_st.cmd = c;
            nxt_st.bitCnt = 5'h00;
            nxt_st.idIdx = 5'h00;
            nxt_st.outBits = 4'h0;
            // A busy modify cycle sees nothing of these commands
            if (c == CMD_NONE ||
                (modifyBusy && (c == CMD_ID || arrayCmd(c)))) begin
              nxt_st.phase = PH_IGNORE; // RULE6 RULE12
            end else if (c == CMD_ID || c == CMD_RD_VECR) begin
              nxt_st.phase = PH_DATA;
            end else if (c == CMD_WR_VECR) begin
              nxt_st.phase = PH_WRITE;
            end else begin
              nxt_st.phase = PH_ADDR;
            end
          end
        end
        PH_ADDR: begin
          nxt_st.shiftIn = addrShift;
          nxt_st.bitCnt = st_ff.bitCnt + (dualIoAddr ? 5'h02 : 5'h01);
          if (addrDone) begin
            nxt_st.addr = addrShift[ADDR_W-1:0]; // RULE11
            nxt_st.bitCnt = 5'h00;
            nxt_st.dummyCnt = 4'h0;
            nxt_st.phase = (st_ff.cmd == CMD_READ) ? PH_DATA : // RULE9
              PH_DUMMY; // RULE13
          end
        end
        PH_DUMMY: begin
          nxt_st.dummyCnt = st_ff.dummyCnt + 4'h1;
          if (st_ff.dummyCnt == dummyNeed - 4'h1) begin
            nxt_st.phase = PH_DATA; // RULE14
          end
        end
        PH_WRITE: begin
          nxt_st.shiftIn = {st_ff.shiftIn[22:0], din};
          nxt_st.bitCnt = st_ff.bitCnt + 5'h01;
          if (st_ff.bitCnt == OPCODE_LAST_BIT) begin
            // Bits beyond the first byte are dropped
            nxt_st.vecr = opNow; // RULE2
            nxt_st.phase = PH_IGNORE;
          end
        end
        default: nxt_st.phase = st_ff.phase;
      endcase
    end else if (sclkFall && st_ff.phase == PH_DATA) begin
      b = (st_ff.outBits == 4'h0) ? srcByte : st_ff.outByte;
      nxt_st.pins.dataLineOneOut = b[7]; // RULE7 RULE25
      nxt_st.pins.dataLineOneOe = 1'b1;
      nxt_st.pins.dataLineZeroOut = isDual && b[6]; // RULE19
      nxt_st.pins.dataLineZeroOe = isDual;
      nxt_st.outByte = isDual ? {b[5:0], 2'b00} : {b[6:0], 1'b0};
      nxt_st.outBits = ((st_ff.outBits == 4'h0) ? BYTE_BITS : st_ff.outBits)
        - (isDual ? 4'h2 : 4'h1);
      if (loadByte) begin
        if (st_ff.cmd == CMD_ID) begin
          if (st_ff.idIdx != ID_LEN) begin
            nxt_st.idIdx = st_ff.idIdx + 5'h01;
          end
        end else if (arrayCmd(st_ff.cmd) || st_ff.cmd == CMD_SFDP) begin
          // Natural overflow wraps to address zero
          nxt_st.addr = st_ff.addr + 1'b1; // RULE10 RULE20
        end
      end
    end
    nxt_st.arrayRdEn = nxt_st.phase == PH_DATA && arrayCmd(nxt_st.cmd);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff <= CTRL_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pinsOut = st_ff.pins;
  assign arrayAddr = st_ff.addr;
  assign arrayRdEn = st_ff.arrayRdEn;
  assign enhConfig = st_ff.vecr;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence opcodeDone;
    sclkRise && selected && st_ff.phase == PH_OPCODE &&
      st_ff.bitCnt == OPCODE_LAST_BIT;
  endsequence

  sequence lastDummy;
    sclkRise && selected && st_ff.phase == PH_DUMMY &&
      st_ff.dummyCnt == dummyNeed - 4'h1;
  endsequence

  sequence singleLoad;
    loadByte && !isDual;
  endsequence

  a_deselect_ends: assert property ( // RULE8
    !selected |=> st_ff.phase == PH_OPCODE && !pinsOut.dataLineOneOe
      && !pinsOut.dataLineZeroOe)
    else $error("deselect did not end the command");

  a_busy_rejects: assert property ( // RULE12
    opcodeDone and (modifyBusy && (opNow == OP_ID_A || opNow == OP_READ ||
      opNow == OP_FAST || opNow == OP_DUAL_OUT))
      |=> st_ff.phase == PH_IGNORE [*1] ##1 !pinsOut.dataLineOneOe)
    else $error("read accepted during modify cycle");

  a_unique_length: assert property ( // RULE4
    singleLoad and (st_ff.cmd == CMD_ID && st_ff.idIdx == ID_UNIQ_POS)
      |=> {pinsOut.dataLineOneOut, st_ff.outByte[7:1]} == UNIQ_LENGTH)
    else $error("unique block length byte wrong");

  a_factory_blank: assert property ( // RULE5
    singleLoad and (st_ff.cmd == CMD_ID && st_ff.idIdx >= ID_FACT_POS)
      |=> {pinsOut.dataLineOneOut, st_ff.outByte[7:1]} == FACT_BLANK)
    else $error("factory data byte not blank");

  a_msb_first: assert property ( // RULE25
    singleLoad |=> pinsOut.dataLineOneOut == $past(srcByte[7]) &&
      pinsOut.dataLineOneOe && !pinsOut.dataLineZeroOe)
    else $error("data not sent msb first");

  a_addr_advance: assert property ( // RULE10
    loadByte && arrayCmd(st_ff.cmd)
      |=> arrayAddr == ADDR_W'($past(arrayAddr) + 1'b1) && arrayRdEn)
    else $error("read address did not advance");

  a_dual_lines: assert property ( // RULE19
    sclkFall && selected && st_ff.phase == PH_DATA && isDual
      |=> pinsOut.dataLineZeroOe && pinsOut.dataLineOneOe &&
        st_ff.outBits[0] == 1'b0)
    else $error("dual read not on both lines");

  a_vecr_write: assert property ( // RULE2
    sclkRise && selected && st_ff.phase == PH_WRITE &&
      st_ff.bitCnt == OPCODE_LAST_BIT
      |=> enhConfig == $past(opNow) && st_ff.phase == PH_IGNORE)
    else $error("config write byte not stored");

  a_dummy_count: assert property ( // RULE14
    lastDummy |=> st_ff.phase == PH_DATA && st_ff.dummyCnt == dummyNeed)
    else $error("dummy count not honoured");

  a_read_no_dummy: assert property ( // RULE9
    sclkRise && selected && st_ff.phase == PH_ADDR &&
      st_ff.cmd == CMD_READ && addrDone
      |=> st_ff.phase == PH_DATA && arrayAddr == $past(addrShift[21:0]))
    else $error("plain read did not start data");

  a_sfdp_erased: assert property ( // RULE17
    singleLoad and (st_ff.cmd == CMD_SFDP &&
      int'(st_ff.addr[SFDP_AW-1:0]) >= SFDP_WRITTEN)
      |=> {pinsOut.dataLineOneOut, st_ff.outByte[7:1]} == ERASED_BYTE)
    else $error("unwritten discovery byte not erased");
endmodule
`default_nettype wire

// *** dv/spi_host_model.sv ***
// Host controller model for the serial flash link, one frame per call.
// Assumes mode 0, a 400 ns link clock built from eight clk_sys cycles.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model import flash_read_pkg::*; (
  input wire logic clk_sys,
  input wire pin_out_type pinsOut,
  output var pin_in_type pinsIn
);
  logic sclk, chipSelN, hostD0, hostD1, hostOe0, hostOe1;
  logic noise = 1'b0;

  initial begin
    sclk = 1'b0;
    chipSelN = 1'b1;
    hostD0 = 1'b0;
    hostD1 = 1'b0;
    hostOe0 = 1'b0;
    hostOe1 = 1'b0;
  end

  // No pulls on the data lines: a released line must not keep its last bit
  always @(posedge clk_sys) noise <= ~noise;

  always_comb begin
    pinsIn.sclk = sclk;
    pinsIn.chipSelN = chipSelN;
    pinsIn.dataLineZeroIn = pinsOut.dataLineZeroOe ? pinsOut.dataLineZeroOut
      : (hostOe0 ? hostD0 : noise);
    pinsIn.dataLineOneIn = pinsOut.dataLineOneOe ? pinsOut.dataLineOneOut
      : (hostOe1 ? hostD1 : noise);
  end

  task automatic clk_n(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Bits change while the link clock is low and are taken at its rise
  task automatic send_edge(input logic d1, input logic d0, input logic dual);
    sclk <= 1'b0;
    hostD0 <= d0;
    hostD1 <= d1;
    hostOe1 <= dual;
    clk_n(4);
    sclk <= 1'b1;
    clk_n(4);
  endtask

  task automatic frame(input logic [7:0] op, input logic [23:0] addr,
      input int nAddr, input logic dualAddr, input int nDummy,
      input int nRx, input logic dualRx,
      output logic [7:0] rx [24], output logic oeSeen);
    logic [7:0] b;
    int k;
    int i;
    oeSeen = 1'b0;
    b = 8'h00;
    @(posedge clk_sys);
    chipSelN <= 1'b0;
    hostOe0 <= 1'b1;
    clk_n(4);
    for (i = 7; i >= 0; i--) send_edge(1'b0, op[i], 1'b0);
    for (k = 0; k < nAddr; k++) begin
      if (dualAddr) begin
        send_edge(addr[23-2*k], addr[22-2*k], 1'b1);
      end else begin
        send_edge(1'b0, addr[23-k], 1'b0);
      end
    end
    for (k = 0; k < nDummy; k++) send_edge(1'b0, 1'b0, 1'b0);
    for (k = 0; k < nRx; k++) begin
      for (i = 0; i < (dualRx ? 4 : 8); i++) begin
        sclk <= 1'b0;
        hostOe0 <= ~dualRx;
        hostOe1 <= 1'b0;
        clk_n(4);
        sclk <= 1'b1;
        oeSeen = oeSeen | pinsOut.dataLineOneOe;
        // Read the shared lines, so an undriven line shows noise
        if (dualRx) begin
          b = {b[5:0], pinsIn.dataLineOneIn, pinsIn.dataLineZeroIn};
        end else begin
          b = {b[6:0], pinsIn.dataLineOneIn};
        end
        clk_n(4);
      end
      rx[k] = b;
    end
    sclk <= 1'b0;
    clk_n(4);
    chipSelN <= 1'b1;
    hostOe0 <= 1'b0;
    hostOe1 <= 1'b0;
    clk_n(8);
  endtask
endmodule
`default_nettype wire

// *** dv/tb_flash_read_engine.sv ***
// Self-checking bench of the flash read-command engine.
// Assumes the host model drives the pins and a byte array answers reads.
`timescale 1ns/1ps
`default_nettype none
module tb_flash_read_engine;
  import flash_read_pkg::*;
  localparam logic [7:0] ID_MAKER = 8'h5c; // Arbitrary value
  localparam logic [7:0] ID_TYPE = 8'h3e; // Arbitrary value
  localparam logic [7:0] ID_SIZE = 8'h7d; // Arbitrary value
  localparam logic [15:0] ID_EXT = 16'h2a61; // Arbitrary value
  localparam logic [55:0] SFDP_EXP = 56'hffff53464450ff;
  logic clk_sys, reset, modifyBusy, arrayRdEn, oe;
  logic [3:0] fastDummyCycles;
  logic [7:0] arrayData, enhConfig;
  logic [ADDR_W-1:0] arrayAddr;
  logic [7:0] rx [24];
  pin_in_type pinsIn;
  pin_out_type pinsOut;
  int errTotal = 0;
  int nCompared = 0;

  flash_read_engine #(
    .MFR_CODE(ID_MAKER),
    .MEM_TYPE(ID_TYPE),
    .MEM_CAPACITY(ID_SIZE),
    .EXT_ID(ID_EXT)
  ) flash_read_engine_inst (
    .clk_sys(clk_sys),
    .reset(reset),
    .pinsIn(pinsIn),
    .modifyBusy(modifyBusy),
    .fastDummyCycles(fastDummyCycles),
    .arrayData(arrayData),
    .pinsOut(pinsOut),
    .arrayAddr(arrayAddr),
    .arrayRdEn(arrayRdEn),
    .enhConfig(enhConfig)
  );

  spi_host_model spi_host_model_inst (
    .clk_sys(clk_sys),
    .pinsOut(pinsOut),
    .pinsIn(pinsIn)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Array content mixes high address bits so a wrap shows up as a new value
  function automatic logic [7:0] patt(input logic [ADDR_W-1:0] a);
    return a[7:0] + a[21:14];
  endfunction

  // Array answers only while the read enable stands
  always @(posedge clk_sys) arrayData <= arrayRdEn ? patt(arrayAddr) : 8'h00;

  task automatic check(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic testDone();
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic run_frame(input logic [7:0] op, input logic [23:0] addr,
      input int nAddr, input logic dualAddr, input int nDummy,
      input int nRx, input logic dualRx);
    spi_host_model_inst.frame(op, addr, nAddr, dualAddr, nDummy, nRx,
      dualRx, rx, oe);
    check("lines released", 8'h00, {5'h0, arrayRdEn,
      pinsOut.dataLineOneOe, pinsOut.dataLineZeroOe});
  endtask

  task automatic read_check(input logic [7:0] op, input logic [23:0] addr,
      input logic dual, input int nDummy);
    run_frame(op, addr, dual ? 12 : 24, dual, nDummy, 3, op != OP_READ &&
      op != OP_FAST);
    check("read drive", 8'h01, {7'h0, oe});
    for (int k = 0; k < 3; k++) check("array byte",
      patt(addr[21:0] + 22'(k)), rx[k]);
  endtask

  task automatic set_dummy(input logic [3:0] n);
    @(posedge clk_sys);
    fastDummyCycles <= n;
  endtask

  task automatic test_config();
    check("config reset", 8'hff, enhConfig);
    run_frame(OP_WR_VECR, 24'ha50000, 8, 1'b0, 0, 0, 1'b0);
    check("config write", 8'ha5, enhConfig);
    run_frame(OP_RD_VECR, 24'h0, 0, 1'b0, 0, 3, 1'b0);
    for (int k = 0; k < 3; k++) check("config read", 8'ha5, rx[k]);
  endtask

  task automatic test_ident();
    logic [7:0] e;
    run_frame(OP_ID_B, 24'h0, 0, 1'b0, 0, 20, 1'b0);
    for (int k = 0; k < 20; k++) begin
      case (k)
        0: e = ID_MAKER;
        1: e = ID_TYPE;
        2: e = ID_SIZE;
        3: e = 8'h10;
        4: e = ID_EXT[15:8];
        5: e = ID_EXT[7:0];
        default: e = 8'h00;
      endcase
      check("id byte", e, rx[k]);
    end
    run_frame(OP_ID_A, 24'h0, 0, 1'b0, 0, 2, 1'b0);
    check("id restart", ID_TYPE, rx[1]);
  endtask

  task automatic test_single();
    read_check(OP_READ, 24'hfffffe, 1'b0, 0);
    set_dummy(4'h0);
    read_check(OP_FAST, 24'h812345, 1'b0, 8);
    set_dummy(4'h4);
    read_check(OP_FAST, 24'h000ffe, 1'b0, 4);
  endtask

  task automatic test_discovery();
    run_frame(OP_SFDP, 24'h4007fe, 24, 1'b0, 8, 7, 1'b0);
    for (int k = 0; k < 7; k++) check("discovery byte",
      SFDP_EXP[55-8*k -: 8], rx[k]);
  endtask

  task automatic test_dual();
    set_dummy(4'h0);
    read_check(OP_DUAL_OUT, 24'h7ffffe, 1'b0, 8);
    read_check(OP_DUAL_IO, 24'h00a5c3, 1'b1, 8);
  endtask

  task automatic test_busy();
    @(posedge clk_sys);
    modifyBusy <= 1'b1;
    run_frame(OP_READ, 24'h000100, 24, 1'b0, 0, 1, 1'b0);
    check("busy read drive", 8'h00, {7'h0, oe});
    run_frame(OP_FAST, 24'h000100, 24, 1'b0, 8, 1, 1'b0);
    check("busy fast drive", 8'h00, {7'h0, oe});
    run_frame(OP_ID_B, 24'h0, 0, 1'b0, 0, 1, 1'b0);
    check("busy id drive", 8'h00, {7'h0, oe});
    @(posedge clk_sys);
    modifyBusy <= 1'b0;
    run_frame(OP_ID_B, 24'h0, 0, 1'b0, 0, 1, 1'b0);
    check("id after busy", ID_MAKER, rx[0]);
  endtask

  initial begin
    reset = 1'b1;
    modifyBusy = 1'b0;
    fastDummyCycles = 4'h0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (5) @(posedge clk_sys);
    test_config();
    test_ident();
    test_single();
    test_discovery();
    test_dual();
    test_busy();
    testDone();
  end

  // The full sequence needs about six thousand cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    errTotal++;
    testDone();
  end
endmodule
`default_nettype wire
